//--- include/ebm_pkg.sv
// Constants and types for the external bus mode controller
package ebm_pkg;
    localparam logic [7:0] EBM_CONFIG0_OFF = 8'h00;
    localparam logic [7:0] EBM_WINDOW_CFG_OFF = 8'h04;
    localparam logic [7:0] EBM_WINDOW_SEL_OFF = 8'h14;
    localparam logic [7:0] EBM_SYSCFG_OFF = 8'h24;
    localparam logic [7:0] EBM_STATUS_OFF = 8'h28;
    localparam logic [7:0] EBM_INTERNAL_OFF = 8'h2c;
    localparam logic [7:0] EBM_LAST_OFF = 8'h2c;
    // Config fields: bus type [1:0], active bit [2], command delay [5:3]
    localparam int EBM_TYPE_LSB = 0;
    localparam int EBM_ACTIVE_BIT = 2;
    localparam int EBM_DELAY_LSB = 3;
    localparam logic [15:0] EBM_CONFIG_RST = 16'h0000;
    localparam logic [15:0] EBM_SEL_RST = 16'h0000;
    localparam logic [15:0] EBM_SYSCFG_RST = 16'h0000;
    localparam logic [7:0] EBM_INTERNAL_RST = 8'h00;
    // Window select: base segment [15:8], segment count mask [7:0]
    localparam int EBM_SEGMENTATION_DISABLE_BIT = 0;
    localparam int EBM_SEGMENT_LINE_SELECT_LSB = 0;
    localparam int EBM_CHIP_SELECT_COUNT_LSB = 2;
    localparam int EBM_RSTTYPE_LSB = 6;
    localparam int EBM_LEN_CYCLES = 2;
    localparam int EBM_SYNC_STAGES = 3;
    typedef enum logic [1:0]
    {
        EBM_T_8DEMUX = 2'b00,
        EBM_T_8MUX = 2'b01,
        EBM_T_16DEMUX = 2'b10,
        EBM_T_16MUX = 2'b11
    } ebm_type_t;
    typedef enum logic [2:0]
    {
        EBM_IDLE = 3'b000,
        EBM_LATCH = 3'b001,
        EBM_EXTRA = 3'b010,
        EBM_DELAY = 3'b011,
        EBM_CMD = 3'b100,
        EBM_DONE = 3'b101
    } ebm_state_t;
endpackage

//--- hw/ebm_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ebm_sync
    import ebm_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pins
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Change counts once second and third stage agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2[i] == s3[i])
                    level[i] <= s3[i];
            end
        end
    end
endmodule

//--- hw/ebm_ctrl.sv
// External bus mode controller with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module ebm_ctrl
    import ebm_pkg::*;
#(
    parameter int NWIN = 4
)
(
    // Bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core access request
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [23:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    output logic acc_done,
    output logic [15:0] acc_rdata,
    output logic illegal_bus_trap,
    output logic segmentation_disable,
    // Reset straps
    input wire logic external_access_pin,
    input wire logic [7:0] reset_config_byte,
    // External bus pins
    output logic ale,
    output logic rd_n,
    output logic write_low_strobe,
    output logic write_high_strobe,
    output logic [15:0] muxed_data_port_out,
    output logic muxed_port_low_oe,
    output logic muxed_port_high_oe,
    input wire logic [15:0] muxed_data_port_in,
    output logic [15:0] address_port,
    output logic address_port_oe,
    output logic [6:0] segment_port,
    output logic [3:0] chip_select_n
);
    initial
    begin
        if (NWIN < 1 || NWIN > 4)
            $error("NWIN must be 1 to 4");
    end

    logic [15:0] default_bus_config;
    logic [15:0] bus_config_regs [NWIN];
    logic [15:0] window_select_regs [NWIN];
    logic [15:0] system_config_reg;
    logic [7:0] internal_seg;
    logic [7:0] strap_byte;
    logic strap_ea;
    logic strap_taken;
    logic [7:0] sync_byte;
    logic sync_ea;
    ebm_state_t state;
    logic [15:0] cur_cfg;
    logic [2:0] cur_win;
    logic [23:0] cur_addr;
    logic cur_write;
    logic [15:0] cur_wdata;
    logic [2:0] cnt;
    logic last_demux;
    logic ph_write;
    logic [7:0] ph_addr;

    ebm_sync #(.WIDTH(9)) u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({external_access_pin, reset_config_byte}),
        .level({sync_ea, sync_byte})
    );

    // Straps taken once, after release and synchroniser fill
    logic [2:0] strap_wait;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strap_wait <= 3'h0;
            strap_taken <= 1'b0;
            strap_ea <= 1'b0;
            strap_byte <= 8'h00;
        end
        else if (!strap_taken)
        begin
            strap_wait <= strap_wait + 3'h1;
            if (strap_wait == 3'h4)
            begin
                strap_taken <= 1'b1;
                strap_ea <= sync_ea;
                strap_byte <= sync_byte;
            end
        end
    end

    // AHB-Lite address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready)
        begin
            ph_write <= hsel && htrans[1] && hwrite;
            ph_addr <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            default_bus_config <= EBM_CONFIG_RST;
            system_config_reg <= EBM_SYSCFG_RST;
            internal_seg <= EBM_INTERNAL_RST;
            for (int i = 0; i < NWIN; i++)
            begin
                bus_config_regs[i] <= EBM_CONFIG_RST;
                window_select_regs[i] <= EBM_SEL_RST;
            end
        end
        else
        begin
            if (strap_wait == 3'h4 && !strap_taken)
            begin
                // High pin: single chip, default cleared
                if (sync_ea)
                    default_bus_config <= EBM_CONFIG_RST;
                else
                begin
                    default_bus_config <= EBM_CONFIG_RST;
                    default_bus_config[EBM_TYPE_LSB +: 2] <= sync_byte[EBM_RSTTYPE_LSB +: 2];
                    default_bus_config[EBM_ACTIVE_BIT] <= 1'b1;
                end
            end
            else if (ph_write)
            begin
                if (ph_addr == EBM_CONFIG0_OFF)
                    default_bus_config <= hwdata[15:0];
                if (ph_addr == EBM_SYSCFG_OFF)
                    system_config_reg <= hwdata[15:0];
                if (ph_addr == EBM_INTERNAL_OFF)
                    internal_seg <= hwdata[7:0];
                for (int i = 0; i < NWIN; i++)
                begin
                    if (ph_addr == EBM_WINDOW_CFG_OFF + 8'(4 * i))
                        bus_config_regs[i] <= hwdata[15:0];
                    if (ph_addr == EBM_WINDOW_SEL_OFF + 8'(4 * i))
                        window_select_regs[i] <= hwdata[15:0];
                end
            end
        end
    end

    assign segmentation_disable = system_config_reg[EBM_SEGMENTATION_DISABLE_BIT];

    // Read mux; unmapped reads zero
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ph_addr == EBM_CONFIG0_OFF)
            hrdata[15:0] = default_bus_config;
        if (ph_addr == EBM_SYSCFG_OFF)
            hrdata[15:0] = system_config_reg;
        if (ph_addr == EBM_INTERNAL_OFF)
            hrdata[7:0] = internal_seg;
        if (ph_addr == EBM_STATUS_OFF)
            hrdata[15:0] = {strap_byte, 3'h0, strap_ea, last_demux, state};
        for (int i = 0; i < NWIN; i++)
        begin
            if (ph_addr == EBM_WINDOW_CFG_OFF + 8'(4 * i))
                hrdata[15:0] = bus_config_regs[i];
            if (ph_addr == EBM_WINDOW_SEL_OFF + 8'(4 * i))
                hrdata[15:0] = window_select_regs[i];
        end
    end

    // Address classification: internal, lowest window hit, else default
    logic is_internal;
    logic [2:0] hit_win;
    logic [15:0] hit_cfg;
    logic any_active;
    logic any_demux;
    always_comb
    begin
        is_internal = acc_addr[23:16] == internal_seg;
        hit_win = 3'h0;
        hit_cfg = default_bus_config;
        any_active = default_bus_config[EBM_ACTIVE_BIT];
        any_demux = default_bus_config[EBM_ACTIVE_BIT] && !default_bus_config[EBM_TYPE_LSB];
        for (int i = NWIN - 1; i >= 0; i--)
        begin
            if (bus_config_regs[i][EBM_ACTIVE_BIT])
            begin
                any_active = 1'b1;
                if (!bus_config_regs[i][EBM_TYPE_LSB])
                    any_demux = 1'b1;
                if (((acc_addr[23:16] ^ window_select_regs[i][15:8])
                    & ~window_select_regs[i][7:0]) == 8'h00)
                begin
                    hit_win = 3'(i + 1);
                    hit_cfg = bus_config_regs[i];
                end
            end
        end
    end

    logic cur_mux;
    logic cur_wide;
    assign cur_mux = cur_cfg[EBM_TYPE_LSB];
    assign cur_wide = cur_cfg[EBM_TYPE_LSB + 1];

    // Segment line count and chip select count from straps
    logic [6:0] seg_mask;
    logic [3:0] cs_mask;
    always_comb
    begin
        case (strap_byte[EBM_SEGMENT_LINE_SELECT_LSB +: 2])
            2'b11: seg_mask = 7'h03;
            2'b10: seg_mask = 7'h1f;
            2'b01: seg_mask = 7'h00;
            default: seg_mask = 7'h0f;
        endcase
        case (strap_byte[EBM_CHIP_SELECT_COUNT_LSB +: 2])
            2'b11: cs_mask = 4'hf;
            2'b10: cs_mask = 4'h0;
            2'b01: cs_mask = 4'h3;
            default: cs_mask = 4'h7;
        endcase
        if (segmentation_disable)
            seg_mask = 7'h00;
    end

    // Cycle sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= EBM_IDLE;
            cur_cfg <= EBM_CONFIG_RST;
            cur_win <= 3'h0;
            cur_addr <= 24'h00_0000;
            cur_write <= 1'b0;
            cur_wdata <= 16'h0000;
            cnt <= 3'h0;
            last_demux <= 1'b0;
            acc_done <= 1'b0;
            illegal_bus_trap <= 1'b0;
            acc_rdata <= 16'h0000;
        end
        else
        begin
            acc_done <= 1'b0;
            illegal_bus_trap <= 1'b0;
            case (state)
                EBM_IDLE:
                begin
                    // Request still high beside the last done pulse is the old one
                    if (acc_req && strap_taken && !acc_done && !is_internal)
                    begin
                        if (!hit_cfg[EBM_ACTIVE_BIT])
                        begin
                            illegal_bus_trap <= 1'b1;
                            acc_done <= 1'b1;
                        end
                        else
                        begin
                            cur_cfg <= hit_cfg;
                            cur_win <= hit_win;
                            cur_addr <= acc_addr;
                            cur_write <= acc_write;
                            cur_wdata <= acc_wdata;
                            cnt <= 3'h0;
                            state <= EBM_LATCH;
                        end
                    end
                    else if (acc_req && strap_taken && !acc_done)
                        acc_done <= 1'b1;
                end
                EBM_LATCH:
                begin
                    if (cur_mux && last_demux)
                        state <= EBM_EXTRA;
                    else
                        state <= EBM_DELAY;
                end
                EBM_EXTRA:
                    state <= EBM_DELAY;
                EBM_DELAY:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt >= cur_cfg[EBM_DELAY_LSB +: 3])
                    begin
                        cnt <= 3'h0;
                        state <= EBM_CMD;
                    end
                end
                EBM_CMD:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(EBM_LEN_CYCLES - 1))
                    begin
                        if (!cur_write)
                            acc_rdata <= cur_wide ? muxed_data_port_in
                                : {8'h00, muxed_data_port_in[7:0]};
                        state <= EBM_DONE;
                    end
                end
                EBM_DONE:
                begin
                    last_demux <= !cur_mux;
                    acc_done <= 1'b1;
                    state <= EBM_IDLE;
                end
                default:
                    state <= EBM_IDLE;
            endcase
        end
    end

    // Pin drive, registered
    logic in_cycle;
    assign in_cycle = state != EBM_IDLE;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ale <= 1'b0;
            rd_n <= 1'b1;
            write_low_strobe <= 1'b1;
            write_high_strobe <= 1'b1;
            muxed_data_port_out <= 16'h0000;
            muxed_port_low_oe <= 1'b0;
            muxed_port_high_oe <= 1'b0;
            address_port <= 16'h0000;
            address_port_oe <= 1'b0;
            segment_port <= 7'h00;
            chip_select_n <= 4'hf;
        end
        else
        begin
            ale <= state == EBM_LATCH || state == EBM_EXTRA;
            rd_n <= !(state == EBM_CMD && !cur_write);
            write_low_strobe <= !(state == EBM_CMD && cur_write);
            write_high_strobe <= !(state == EBM_CMD && cur_write && cur_wide);
            address_port_oe <= any_demux;
            if (state == EBM_LATCH)
            begin
                address_port <= cur_addr[15:0];
                segment_port <= cur_addr[22:16] & seg_mask;
                chip_select_n <= ~(cs_mask & (4'h1 << cur_win[1:0]));
                if (cur_win == 3'h0 && cs_mask[0] == 1'b0)
                    chip_select_n <= 4'hf;
            end
            if (state == EBM_LATCH && !(cur_mux && last_demux)
                || state == EBM_EXTRA)
            begin
                if (cur_mux)
                begin
                    muxed_data_port_out <= cur_addr[15:0];
                    muxed_port_low_oe <= 1'b1;
                    muxed_port_high_oe <= 1'b1;
                end
                else
                begin
                    muxed_port_low_oe <= 1'b0;
                    muxed_port_high_oe <= 1'b0;
                end
            end
            else if (state == EBM_DELAY && cur_cfg[EBM_DELAY_LSB +: 3] == cnt)
            begin
                // Address removed, except the high byte in 8-bit muxed mode; write data takes its place
                muxed_data_port_out[7:0] <= cur_wdata[7:0];
                if (cur_wide || !cur_mux)
                    muxed_data_port_out[15:8] <= cur_wdata[15:8];
                muxed_port_low_oe <= cur_write;
                muxed_port_high_oe <= cur_write && cur_wide
                    || cur_mux && !cur_wide;
            end
            if (!in_cycle && !any_active)
            begin
                muxed_port_low_oe <= 1'b0;
                muxed_port_high_oe <= 1'b0;
            end
        end
    end
    // address port updates only at the next cycle's latch state
endmodule

//--- sim/ebm_ctrl_sva.sv
// Bus pin timing checker for the external bus mode controller
`timescale 1ns/100ps
module ebm_ctrl_chk
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched outputs
    input wire logic ale,
    input wire logic rd_n,
    input wire logic write_low_strobe,
    input wire logic write_high_strobe,
    input wire logic [15:0] muxed_data_port_out,
    input wire logic muxed_port_low_oe,
    input wire logic acc_done,
    input wire logic illegal_bus_trap
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    trap_has_done_a: assert property (illegal_bus_trap |-> acc_done)
        else $error("trap without access completion");
    trap_no_ale_a: assert property (illegal_bus_trap |-> !ale && !$past(ale))
        else $error("latch strobe on a trapped access");
    cmd_excl_a: assert property (!(!rd_n && !write_low_strobe))
        else $error("read and write command together");
    cmd_no_ale_a: assert property ((!rd_n || !write_low_strobe) |-> !ale)
        else $error("command while latch strobe high");
    ale_then_cmd_a: assert property ($rose(ale) |-> ##[1:16]
        (!rd_n || !write_low_strobe || !write_high_strobe))
        else $error("latch strobe without a command");
    read_len_a: assert property ($fell(rd_n) |-> !rd_n[*2] ##1 rd_n)
        else $error("read command length wrong");
    write_len_a: assert property ($fell(write_low_strobe) |-> !write_low_strobe[*2])
        else $error("write command too short");
    wr_hold_a: assert property ($rose(write_low_strobe) |->
        muxed_port_low_oe && $stable(muxed_data_port_out[7:0]))
        else $error("write data not held past command");
    rd_release_a: assert property (!rd_n |-> !muxed_port_low_oe)
        else $error("controller drives port during read");
endmodule

bind ebm_ctrl ebm_ctrl_chk u_chk(.hclk(hclk), .hresetn(hresetn), .ale(ale), .rd_n(rd_n),
    .write_low_strobe(write_low_strobe), .write_high_strobe(write_high_strobe),
    .muxed_data_port_out(muxed_data_port_out), .muxed_port_low_oe(muxed_port_low_oe),
    .acc_done(acc_done), .illegal_bus_trap(illegal_bus_trap));

//--- sim/ebm_ext_mem.sv
// External memory model on the controller's bus pins
`timescale 1ns/100ps
module ebm_ext_mem
(
    // Clock
    input wire logic hclk,
    // Bus pins from the controller
    input wire logic ale,
    input wire logic rd_n,
    input wire logic write_low_strobe,
    input wire logic write_high_strobe,
    input wire logic [15:0] muxed_data_port_out,
    input wire logic muxed_port_low_oe,
    input wire logic muxed_port_high_oe,
    input wire logic [15:0] address_port,
    input wire logic [6:0] segment_port,
    // Wire level back to the controller
    output logic [15:0] muxed_data_port_in
);
    logic [15:0] rdat = 16'h3c96;
    logic [15:0] la_mux = 16'h0000;
    logic [15:0] la_dmx = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [6:0] la_seg = 7'h00;
    logic hw = 1'b0;
    logic pale = 1'b0;
    int ale_len = 0;
    int nale = 0;
    // Drives only while read command low; undriven bytes drift
    assign #30 muxed_data_port_in = !rd_n ? rdat :
        {muxed_port_high_oe ? muxed_data_port_out[15:8] : ~rdat[15:8],
        muxed_port_low_oe ? muxed_data_port_out[7:0] : ~rdat[7:0]};
    // Mid-cycle sampling, clear of the controller's edge
    always @(negedge hclk)
    begin
        if (ale)
        begin
            ale_len <= pale ? ale_len + 1 : 1;
            la_mux <= muxed_data_port_out;
            la_dmx <= address_port;
            la_seg <= segment_port;
        end
        nale <= nale + int'(ale && !pale);
        pale <= ale;
        if (!write_low_strobe)
            wd[7:0] <= muxed_data_port_out[7:0];
        if (!write_high_strobe)
        begin
            wd[15:8] <= muxed_data_port_out[15:8];
            hw <= 1'b1;
        end
    end
endmodule

//--- sim/ebm_ctrl_tb_top.sv
// Self-checking testbench for the external bus mode controller
`timescale 1ns/100ps
module ebm_ctrl_tb_top
    import ebm_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, acc_req = 0, acc_write = 0, ea = 1;
    logic [7:0] haddr = 8'h00, rcb = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [23:0] acc_addr = 24'h0;
    logic [15:0] acc_rdata, mdo, mdi, aport;
    logic hrdy, trp, sgd, ale, rd_n, wlo, whi, loe, hoe, aoe, trap;
    logic [6:0] seg;
    logic [3:0] csn;
    int err_count = 0, checks_done = 0;
    logic [39:0] cfg [7] = '{{EBM_WINDOW_CFG_OFF, 32'h1d}, {EBM_WINDOW_SEL_OFF, 32'h4001},
        {EBM_WINDOW_CFG_OFF + 8'h04, 32'h06}, {EBM_WINDOW_SEL_OFF + 8'h04, 32'h2000},
        {EBM_WINDOW_CFG_OFF + 8'h08, 32'h06}, {EBM_WINDOW_SEL_OFF + 8'h08, 32'h4000},
        {EBM_CONFIG0_OFF, 32'h07}};

    ebm_ctrl dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(), .acc_req(acc_req), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(16'habcd), .acc_done(), .acc_rdata(acc_rdata),
        .illegal_bus_trap(trp), .segmentation_disable(sgd), .external_access_pin(ea),
        .reset_config_byte(rcb), .ale(ale), .rd_n(rd_n), .write_low_strobe(wlo),
        .write_high_strobe(whi), .muxed_data_port_out(mdo), .muxed_port_low_oe(loe),
        .muxed_port_high_oe(hoe), .muxed_data_port_in(mdi), .address_port(aport),
        .address_port_oe(aoe), .segment_port(seg), .chip_select_n(csn));
    ebm_ext_mem mem(.hclk(hclk), .ale(ale), .rd_n(rd_n), .write_low_strobe(wlo),
        .write_high_strobe(whi), .muxed_data_port_out(mdo), .muxed_port_low_oe(loe),
        .muxed_port_high_oe(hoe), .address_port(aport), .segment_port(seg),
        .muxed_data_port_in(mdi));

    initial forever #50 hclk = ~hclk;

    task finish_test;
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hrdy !== 1'b1)
            @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hrdy !== 1'b1)
            @(posedge hclk);
        r = hrdata;
    endtask

    task rst(input logic e, input logic [7:0] sb);
        hresetn <= 1'b0;
        ea <= e;
        rcb <= sb;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask

    task acc(input logic [23:0] a, input logic w, output logic [15:0] r);
        int n;
        acc_req <= 1'b1;
        acc_addr <= a;
        acc_write <= w;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end
        while (dut.acc_done !== 1'b1 && n < 100);
        chk("done", dut.acc_done, 1);
        r = acc_rdata;
        trap = trp;
        @(posedge hclk);
        acc_req <= 1'b0;
        repeat (24) @(posedge hclk);
    endtask

    task ext(input logic [23:0] a, input logic w, input ebm_type_t ty, input logic ex,
        input logic dx);
        logic [15:0] r;
        mem.hw = 1'b0;
        mem.wd = 16'h0;
        acc(a, w, r);
        chk("trap", trap, 0);
        chk("ale len", mem.ale_len, 1 + ex);
        // Strap byte selects five segment lines and no chip selects
        chk("seg", mem.la_seg, a[22:16] & 7'h1f);
        chk("cs", csn, 4'hf);
        if (ty[0])
            chk("mux addr", mem.la_mux, a[15:0]);
        if (dx)
            chk("addr port", {aoe, mem.la_dmx}, {1'b1, a[15:0]});
        if (w)
            chk("wdata", mem.wd, ty[1] ? 16'habcd : 16'h00cd);
        else
            chk("rdata", r, ty[1] ? 16'h3c96 : 16'h0096);
    endtask

    initial
    begin
        logic [31:0] r;
        logic [15:0] d;
        int n0;
        rst(1'b0, 8'h8a);
        ahb(EBM_STATUS_OFF, 0, 0, r);
        chk("strap", r[15:0] & 16'hff10, 16'h8a00);
        ahb(EBM_CONFIG0_OFF, 0, 0, r);
        chk("cfg0", r[2:0], 3'b110);
        ext(24'h13_5a3c, 1, EBM_T_16DEMUX, 0, 1);
        ext(24'h13_5a3c, 0, EBM_T_16DEMUX, 0, 1);
        n0 = mem.nale;
        acc(24'h00_1234, 0, d);
        chk("int ale", mem.nale, n0);
        chk("int trap", trap, 0);
        // Windows change only while no access is under way
        foreach (cfg[i])
            ahb(cfg[i][39:32], 1, cfg[i][31:0], r);
        ext(24'h40_5a3c, 0, EBM_T_8MUX, 1, 1);
        ext(24'h41_a5c3, 1, EBM_T_8MUX, 0, 1);
        ext(24'h30_5a3c, 0, EBM_T_16MUX, 0, 1);
        ext(24'h20_5a3c, 1, EBM_T_16DEMUX, 0, 1);
        ext(24'h30_5a3c, 1, EBM_T_16MUX, 1, 1);
        ahb(EBM_SYSCFG_OFF, 1, 32'h1, r);
        @(negedge hclk);
        chk("segmentation_disable", sgd, 1);
        ahb(8'h30, 1, 32'hffff, r);
        ahb(8'h30, 0, 0, r);
        chk("unmapped", r, 0);
        rst(1'b1, 8'h8a);
        ahb(EBM_STATUS_OFF, 0, 0, r);
        chk("ea strap", r[4], 1);
        ahb(EBM_CONFIG0_OFF, 0, 0, r);
        chk("cfg0 clr", r[15:0], 16'h0000);
        n0 = mem.nale;
        acc(24'h13_5a3c, 1, d);
        chk("trap", trap, 1);
        chk("trap ale", mem.nale, n0);
        ahb(EBM_CONFIG0_OFF, 1, 32'h05, r);
        ext(24'h13_5a3c, 1, EBM_T_8MUX, 0, 0);
        ahb(EBM_CONFIG0_OFF, 1, 32'h04, r);
        ext(24'h13_5a3c, 0, EBM_T_8DEMUX, 0, 1);
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge hclk);
        err_count++;
        finish_test;
    end
endmodule
